//--- core/hse_pkg.sv
// shared constants and types of the two-wire host engine
// assumes an AXI4-Lite master with 32-bit data and a 4-bit byte address
package hse_pkg;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int AXI_AW = 4;
  localparam int AXI_DW = 32;
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] ADDR_STAT = 4'h4;
  localparam logic [AXI_AW-1:0] ADDR_BUF = 4'h8;
  localparam logic [AXI_AW-1:0] ADDR_BAUD = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control bits (match hse_ctrl_s packing)
  localparam int CTRL_EN = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_RX = 2;
  localparam int CTRL_ACKSEQ = 3;
  localparam int CTRL_ACKVAL = 4;
  localparam int CTRL_IE = 5;

  // status bits; flags 0..2 and 5 are write-one-to-clear
  localparam int STAT_IF = 0;
  localparam int STAT_WRITE_COLLISION_FLAG = 1;
  localparam int STAT_OVF = 2;
  localparam int STAT_BF = 3;
  localparam int STAT_ACKST = 4;
  localparam int STAT_STOPDET = 5;
  localparam int STAT_BUSY = 6;

  // --------------------------------------------------------------
  // engine constants
  // --------------------------------------------------------------
  localparam int BAUD_W = 8;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 8'h09;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_TX_LOW = 4'b0001,
    ST_TX_HIGH = 4'b0010,
    ST_RX_LOW = 4'b0011,
    ST_RX_HIGH = 4'b0100,
    ST_AK_LOW = 4'b0101,
    ST_AK_HIGH = 4'b0110,
    ST_P_SDA = 4'b0111,
    ST_P_SCL = 4'b1000,
    ST_P_HIGH = 4'b1001,
    ST_P_SDAH = 4'b1010
  } hse_state_e;

  typedef struct packed {
    logic ie;
    logic ack_value_to_send;
    logic ack_sequence_enable;
    logic receive_enable;
    logic stop_request;
    logic enable;
  } hse_ctrl_s;

endpackage

//--- core/hse_baud_gen.sv
// baud generator: reloadable down counter with a rollover pulse
// assumes load and run come from logic on the same clock
`timescale 1ns/1ps
module hse_baud_gen
  import hse_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic load,
  input wire logic run,
  input wire logic [BAUD_W-1:0] divisor,
  // rollover
  output logic tick
);

  logic [BAUD_W-1:0] cnt;

  // a period is divisor+1 cycles; every reload reads the live divisor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= divisor;
    end else if (run) begin
      if (cnt == '0) begin
        cnt <= divisor;
      end else begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign tick = run && !load && (cnt == '0);

endmodule

//--- core/hse_engine.sv
// two-wire host engine: byte transmit, byte receive, ack sequence, stop
// assumes open-drain pads outside; scl_in/sda_in are asynchronous pins
//
// Function
// - stop pulls SDA low, counts after low
// - release SCL, one period later SDA
// - stop seen sets flag, later interrupt
// - buffer write during stop collides, discarded
// - reset disables engine, aborts transfer
// - sleep byte completion wakes when enabled
// - buffer write sets full, starts transmission
// - bit after SCL fall, low/high periods
// - eighth fall clears full, releases SDA
// - client response sampled throughout ninth clock high phase
// - after ninth clock interrupt, SCL low
// - write while shifting out collides, discarded
// - stop request ends transfer, then interrupt
// - receive enable ignored unless engine idle
// - receive toggles SCL per rollover, shifts
// - eighth receive fall loads buffer, idles
// - buffer read clears full; ack follows
// - byte while buffer full sets overflow
// - write while shifting in collides, discarded
// - every reload takes the baud divisor
// - counting waits until SCL reads high
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module hse_engine
  import hse_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // two-wire pads
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // power
  input wire logic sleep_mode,
  output logic wake
);

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_BUF) || (a == ADDR_BAUD);
  endfunction

  hse_state_e state;
  hse_ctrl_s ctrl;
  logic [BAUD_W-1:0] baud_divisor_register;
  logic [7:0] transfer_buffer;
  logic [7:0] transmit_shift_register;
  logic [7:0] receive_shift_register;
  logic [3:0] bitcnt;
  logic serial_interrupt_flag, write_collision_flag, receive_overflow_flag;
  logic buffer_full_flag, client_response_status, stop_detected;
  logic scl_m, scl_s, sda_m, sda_s;
  logic bg_run, bg_load, tick;
  logic aw_have, w_have;
  logic [AXI_AW-1:0] aw_addr;
  logic [AXI_DW-1:0] w_data;
  logic [3:0] w_strb;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  // open drain: the pad level is always low, only the enable moves
  always_ff @(posedge aclk) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  // --------------------------------------------------------------
  // bus events
  // --------------------------------------------------------------
  logic wr_go, ctrl_wr, stat_wr, buf_wr, baud_wr, idle, buf_wr_ok, buf_wr_bad;
  logic start_stop, start_rx, start_ack, buf_rd;
  logic tx_fall8, tx_done, rx_done, ack_done, stop_done;

  assign wr_go = aw_have && w_have && !bvalid;
  assign ctrl_wr = wr_go && w_strb[0] && (aw_addr == ADDR_CTRL);
  assign stat_wr = wr_go && w_strb[0] && (aw_addr == ADDR_STAT);
  assign buf_wr = wr_go && w_strb[0] && (aw_addr == ADDR_BUF);
  assign baud_wr = wr_go && w_strb[0] && (aw_addr == ADDR_BAUD);
  assign idle = (state == ST_IDLE) && ctrl.enable;
  assign buf_wr_ok = buf_wr && idle;
  assign buf_wr_bad = buf_wr && !idle;
  assign start_stop = ctrl_wr && idle && w_data[CTRL_STOP];
  assign start_rx = ctrl_wr && idle && !w_data[CTRL_STOP] && w_data[CTRL_RX];
  assign start_ack = ctrl_wr && idle && !w_data[CTRL_STOP] && !w_data[CTRL_RX]
    && w_data[CTRL_ACKSEQ];
  assign buf_rd = arvalid && arready && (araddr == ADDR_BUF);

  assign tx_fall8 = (state == ST_TX_HIGH) && tick && (bitcnt == BIT_LAST);
  assign tx_done = (state == ST_TX_HIGH) && tick && (bitcnt == BIT_ACK);
  assign rx_done = (state == ST_RX_HIGH) && tick && (bitcnt == BIT_LAST);
  assign ack_done = (state == ST_AK_HIGH) && tick;
  assign stop_done = (state == ST_P_SDAH) && tick;

  // --------------------------------------------------------------
  // baud generator control
  // --------------------------------------------------------------
  always_comb begin
    case (state)
      ST_TX_LOW, ST_RX_LOW, ST_AK_LOW, ST_P_SCL: bg_run = 1'b1;
      ST_TX_HIGH, ST_RX_HIGH, ST_AK_HIGH, ST_P_HIGH: bg_run = scl_s;
      ST_P_SDAH: bg_run = sda_s && scl_s;
      default: bg_run = 1'b0;
    endcase
    bg_load = !bg_run;
  end

  hse_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(bg_load),
    .run(bg_run),
    .divisor(baud_divisor_register),
    .tick(tick)
  );

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl.enable) begin
      state <= ST_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      bitcnt <= BIT_FIRST;
      transmit_shift_register <= '0;
      receive_shift_register <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (buf_wr_ok) begin
            state <= ST_TX_LOW;
            transmit_shift_register <= w_data[7:0];
            sda_oe <= !w_data[7];
            scl_oe <= 1'b1;
            bitcnt <= BIT_FIRST;
          end else if (start_stop) begin
            state <= ST_P_SDA;
            sda_oe <= 1'b1;
            scl_oe <= 1'b1;
          end else if (start_rx) begin
            state <= ST_RX_LOW;
            sda_oe <= 1'b0;
            scl_oe <= 1'b1;
            bitcnt <= BIT_FIRST;
          end else if (start_ack) begin
            state <= ST_AK_LOW;
            sda_oe <= !w_data[CTRL_ACKVAL];
            scl_oe <= 1'b1;
          end
        end
        ST_TX_LOW: begin
          if (tick) begin
            state <= ST_TX_HIGH;
            scl_oe <= 1'b0;
          end
        end
        ST_TX_HIGH: begin
          if (tick) begin
            scl_oe <= 1'b1;
            if (bitcnt == BIT_ACK) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_TX_LOW;
              bitcnt <= bitcnt + 1'b1;
              transmit_shift_register <= {transmit_shift_register[6:0], 1'b0};
              sda_oe <= (bitcnt == BIT_LAST) ? 1'b0 : !transmit_shift_register[6];
            end
          end
        end
        ST_RX_LOW: begin
          if (tick) begin
            state <= ST_RX_HIGH;
            scl_oe <= 1'b0;
          end
        end
        ST_RX_HIGH: begin
          if (tick) begin
            scl_oe <= 1'b1;
            receive_shift_register <= {receive_shift_register[6:0], sda_s};
            bitcnt <= bitcnt + 1'b1;
            state <= (bitcnt == BIT_LAST) ? ST_IDLE : ST_RX_LOW;
          end
        end
        ST_AK_LOW: begin
          if (tick) begin
            state <= ST_AK_HIGH;
            scl_oe <= 1'b0;
          end
        end
        ST_AK_HIGH: begin
          if (tick) begin
            state <= ST_IDLE;
            scl_oe <= 1'b1;
          end
        end
        ST_P_SDA: begin
          if (!sda_s) begin
            state <= ST_P_SCL;
          end
        end
        ST_P_SCL: begin
          if (tick) begin
            state <= ST_P_HIGH;
            scl_oe <= 1'b0;
          end
        end
        ST_P_HIGH: begin
          if (tick) begin
            state <= ST_P_SDAH;
            sda_oe <= 1'b0;
          end
        end
        ST_P_SDAH: begin
          if (tick) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // control, buffer and status
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;
      baud_divisor_register <= BAUD_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl.enable <= w_data[CTRL_EN];
        ctrl.ack_value_to_send <= w_data[CTRL_ACKVAL];
        ctrl.ie <= w_data[CTRL_IE];
      end
      // request bits only take effect from idle and self-clear on completion
      ctrl.stop_request <= start_stop || (ctrl.stop_request && !stop_done && ctrl.enable);
      ctrl.receive_enable <= start_rx || (ctrl.receive_enable && !rx_done && ctrl.enable);
      ctrl.ack_sequence_enable <= start_ack
        || (ctrl.ack_sequence_enable && !ack_done && ctrl.enable);
      if (baud_wr) begin
        baud_divisor_register <= w_data[BAUD_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transfer_buffer <= '0;
      buffer_full_flag <= 1'b0;
      client_response_status <= 1'b0;
    end else begin
      if (buf_wr_ok) begin
        transfer_buffer <= w_data[7:0];
      end else if (rx_done) begin
        transfer_buffer <= {receive_shift_register[6:0], sda_s};
      end
      // a fresh byte wins over a simultaneous read
      if (buf_wr_ok || rx_done) begin
        buffer_full_flag <= 1'b1;
      end else if (buf_rd || tx_fall8 || !ctrl.enable) begin
        buffer_full_flag <= 1'b0;
      end
      if (state == ST_TX_HIGH && scl_s && bitcnt == BIT_ACK) begin
        client_response_status <= sda_s;
      end
    end
  end

  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_interrupt_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      stop_detected <= 1'b0;
    end else begin
      serial_interrupt_flag <= (serial_interrupt_flag && !(stat_wr && w_data[STAT_IF]))
        || tx_done || rx_done || ack_done || stop_done;
      write_collision_flag <= (write_collision_flag && !(stat_wr && w_data[STAT_WRITE_COLLISION_FLAG]))
        || buf_wr_bad;
      receive_overflow_flag <= (receive_overflow_flag && !(stat_wr && w_data[STAT_OVF]))
        || (rx_done && buffer_full_flag && !buf_rd);
      stop_detected <= (stop_detected && !(stat_wr && w_data[STAT_STOPDET]))
        || (state == ST_P_SDAH && sda_s && scl_s);
    end
  end

  // client-side byte completion reaches the processor only while asleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake <= 1'b0;
    end else begin
      wake <= sleep_mode && ctrl.ie && (rx_done || tx_done);
    end
  end

  // --------------------------------------------------------------
  // axi4-lite slave
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        bvalid <= 1'b1;
        bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  logic [AXI_DW-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (araddr == ADDR_CTRL) begin
      rd_word[5:0] = ctrl;
    end else if (araddr == ADDR_STAT) begin
      rd_word[STAT_IF] = serial_interrupt_flag;
      rd_word[STAT_WRITE_COLLISION_FLAG] = write_collision_flag;
      rd_word[STAT_OVF] = receive_overflow_flag;
      rd_word[STAT_BF] = buffer_full_flag;
      rd_word[STAT_ACKST] = client_response_status;
      rd_word[STAT_STOPDET] = stop_detected;
      rd_word[STAT_BUSY] = (state != ST_IDLE);
    end else if (araddr == ADDR_BUF) begin
      rd_word[7:0] = transfer_buffer;
    end else if (araddr == ADDR_BAUD) begin
      rd_word[BAUD_W-1:0] = baud_divisor_register;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_stop_sda_first;
    @(posedge aclk) disable iff (!aresetn)
    start_stop |=> (state == ST_P_SDA) && sda_oe && scl_oe;
  endproperty
  a_stop_sda_first: assert property (p_stop_sda_first) else $error("stop did not pull sda");

  property p_stop_release;
    @(posedge aclk) disable iff (!aresetn)
    (state == ST_P_SCL) && tick |=> !scl_oe && sda_oe;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("scl not released first");

  property p_stop_done;
    @(posedge aclk) disable iff (!aresetn)
    $rose(stop_detected) && ctrl.enable |-> ##[1:300] (!ctrl.stop_request && serial_interrupt_flag);
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop never completed");

  property p_write_collision_flag;
    @(posedge aclk) disable iff (!aresetn)
    buf_wr_bad && !rx_done |=> write_collision_flag && $stable(transfer_buffer);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision write not discarded");

  property p_disable;
    @(posedge aclk) disable iff (!aresetn)
    !ctrl.enable |=> (state == ST_IDLE) && !scl_oe && !sda_oe;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled engine still active");

  property p_tx_start;
    @(posedge aclk) disable iff (!aresetn)
    buf_wr_ok |=> buffer_full_flag && (state == ST_TX_LOW) && scl_oe;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("buffer write did not start");

  property p_ack_fall;
    @(posedge aclk) disable iff (!aresetn)
    tx_fall8 |=> !buffer_full_flag && !sda_oe && (bitcnt == BIT_ACK);
  endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("sda not released for ack");

  property p_tx_end;
    @(posedge aclk) disable iff (!aresetn)
    tx_done |=> serial_interrupt_flag && scl_oe && !sda_oe && (state == ST_IDLE)
      ##1 (state == ST_IDLE) [*2];
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("ninth clock end wrong");

  property p_rx_ignored;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_wr && w_data[CTRL_RX] && !idle && !ctrl.receive_enable |=> !ctrl.receive_enable;
  endproperty
  a_rx_ignored: assert property (p_rx_ignored) else $error("receive started while busy");

  property p_overflow;
    @(posedge aclk) disable iff (!aresetn)
    rx_done && buffer_full_flag && !buf_rd |=> receive_overflow_flag && buffer_full_flag;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_stretch;
    @(posedge aclk) disable iff (!aresetn)
    (state == ST_TX_HIGH) && !scl_s |-> bg_load && !tick;
  endproperty
  a_stretch: assert property (p_stretch) else $error("counting during stretch");

  c_tx: cover property (@(posedge aclk) disable iff (!aresetn) tx_done);
  c_rx: cover property (@(posedge aclk) disable iff (!aresetn) rx_done);
  c_stop: cover property (@(posedge aclk) disable iff (!aresetn) stop_done);
  c_write_collision_flag: cover property (@(posedge aclk) disable iff (!aresetn) buf_wr_bad);

endmodule

//--- testbench/hse_client.sv
// client model on the far side of the two-wire pads
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ps
module hse_client (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // bench control
  input wire logic clr,
  input wire logic rx_mode,
  input wire logic nack,
  input wire logic stretch,
  input wire logic [7:0] tx_byte,
  // line drives and capture
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] got
);
  int cnt = 0;
  int slot = 0;
  // rises are counted, so the first fall of a clock that was released does not move the slot
  always @(posedge scl or posedge clr) begin
    if (clr) begin
      cnt <= 0;
      got <= 8'h00;
    end else begin
      if (cnt < 8) begin
        got <= {got[6:0], sda};
      end
      cnt <= cnt + 1;
    end
  end
  always @(negedge scl or posedge clr) begin
    if (clr) begin
      slot <= 0;
    end else begin
      slot <= cnt;
    end
  end
  // sends data in slots 0..7, or answers in the ninth slot; released otherwise
  assign sda_low = rx_mode ? (slot < 8 && !tx_byte[7 - slot]) : (slot == 8 && !nack);
  // the bench raises stretch only while the host holds the clock low, which avoids a false edge
  assign scl_low = stretch;
endmodule

//--- testbench/hse_engine_tb.sv
// self-checking bench for the two-wire host engine
// assumes hse_client on the far side and pull-ups on both lines
`timescale 1ns/1ps
module hse_engine_tb import hse_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [AXI_DW-1:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0] wstrb = 4'hF;
  logic sleep_mode = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_out, scl_oe, sda_out, sda_oe, wake;
  logic [1:0] bresp, rresp, resp;
  logic c_scl_low, c_sda_low, scl, sda;
  logic clr = 1'b0, rx_mode = 1'b0, nack = 1'b0, stretch = 1'b0;
  logic [7:0] tx_byte = 8'h00, got, byte_a;
  logic [31:0] rnd = 32'h420414CF;
  int n_mismatch = 0, n_tests = 0, n_wake = 0;
  assign scl = !scl_oe && !c_scl_low;
  assign sda = !sda_oe && !c_sda_low;
  hse_engine uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sleep_mode(sleep_mode), .wake(wake)
  );
  hse_client client (
    .scl(scl), .sda(sda), .clr(clr), .rx_mode(rx_mode), .nack(nack),
    .stretch(stretch), .tx_byte(tx_byte),
    .scl_low(c_scl_low), .sda_low(c_sda_low), .got(got)
  );
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (wake) begin
      n_wake <= n_wake + 1;
    end
  end
  // ----------------------------------------
  // bus, model and check helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
      end
      if (wready) begin
        wvalid <= 1'b0;
      end
      resp = bresp;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
      end
      rd_v = rdata;
      resp = rresp;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    chk(nm, exp, rd_v);
  endtask
  task automatic wait_if();
    do begin
      rd(ADDR_STAT);
    end while (!rd_v[STAT_IF]);
  endtask
  task automatic prep(input logic rxm, input logic nk, input logic [7:0] b);
    rx_mode <= rxm;
    nack <= nk;
    tx_byte <= b;
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    tally_and_finish();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc("baud", ADDR_BAUD, 32'h09);
    rc("unmapped", 4'h2, 32'h0);
    chk("resp", RESP_SLVERR, resp);
    wr(ADDR_BAUD, 32'h0B);
    chk("bresp", RESP_OKAY, resp);
    wr(4'h6, 32'hFF);
    chk("bresp_bad", RESP_SLVERR, resp);
    wr(ADDR_CTRL, 32'h01);
    rnd = lfsr(rnd);
    byte_a = {rnd[6:0], 1'b0};
    prep(1'b0, 1'b0, 8'h00);
    wr(ADDR_BUF, {24'h0, byte_a});
    rc("stat_busy", ADDR_STAT, 32'h48);
    wr(ADDR_BUF, 32'hA5);
    wr(ADDR_CTRL, 32'h05);
    wait_if();
    chk("client_byte", byte_a, got);
    rc("stat_ack", ADDR_STAT, 32'h03);
    chk("scl_hold", 1, scl_oe);
    rc("ctrl_rx", ADDR_CTRL, 32'h01);
    wr(ADDR_STAT, 32'h27);
    rnd = lfsr(rnd);
    prep(1'b0, 1'b1, 8'h00);
    wr(ADDR_BUF, {24'h0, rnd[7:0]});
    wait_if();
    chk("client_byte2", rnd[7:0], got);
    rc("stat_nack", ADDR_STAT, 32'h11);
    wr(ADDR_STAT, 32'h27);
    rnd = lfsr(rnd);
    byte_a = rnd[7:0];
    prep(1'b1, 1'b0, byte_a);
    wr(ADDR_CTRL, 32'h05);
    wr(ADDR_BUF, 32'h5A);
    // start the stretch only while the host itself holds the clock low
    do @(posedge aclk); while (!scl_oe);
    stretch <= 1'b1;
    repeat (40) @(posedge aclk);
    stretch <= 1'b0;
    wait_if();
    // the not-acknowledge of the second byte still stands in the response bit
    rc("stat_rx", ADDR_STAT, 32'h1B);
    rc("buf_rx", ADDR_BUF, {24'h0, byte_a});
    rc("stat_read", ADDR_STAT, 32'h13);
    wr(ADDR_STAT, 32'h27);
    wr(ADDR_CTRL, 32'h09);
    wait_if();
    rc("ctrl_ack", ADDR_CTRL, 32'h01);
    wr(ADDR_STAT, 32'h01);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      prep(1'b1, 1'b0, rnd[7:0]);
      wr(ADDR_CTRL, 32'h05);
      wait_if();
      wr(ADDR_STAT, 32'h01);
    end
    rc("stat_ovf", ADDR_STAT, 32'h1C);
    rc("buf_ovf", ADDR_BUF, {24'h0, rnd[7:0]});
    wr(ADDR_STAT, 32'h27);
    sleep_mode <= 1'b1;
    wr(ADDR_CTRL, 32'h21);
    prep(1'b0, 1'b0, 8'h00);
    wr(ADDR_BUF, {24'h0, rnd[15:8]});
    wait_if();
    sleep_mode <= 1'b0;
    chk("wake", 1, n_wake);
    wr(ADDR_CTRL, 32'h01);
    wr(ADDR_STAT, 32'h27);
    prep(1'b0, 1'b0, 8'h00);
    wr(ADDR_CTRL, 32'h03);
    wr(ADDR_BUF, 32'h00);
    wait_if();
    rc("ctrl_stop", ADDR_CTRL, 32'h01);
    rc("stat_stop", ADDR_STAT, 32'h23);
    chk("lines", 2'b11, {scl, sda});
    chk("pads", 0, {scl_out, sda_out});
    wr(ADDR_BUF, {24'h0, rnd[23:16]});
    repeat (50) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe_reset", 0, {scl_oe, sda_oe});
    rc("stat_reset", ADDR_STAT, 32'h00);
    rc("ctrl_reset", ADDR_CTRL, 32'h00);
    tally_and_finish();
  end
endmodule
